// ### hdl/noload_consts.svh
/*
 Offsets, field positions and reset values for the no-load
 detector and its interrupt flag registers.
 Assumes inclusion by bare name from the design files.
*/
`ifndef NOLOAD_CONSTS_SVH
`define NOLOAD_CONSTS_SVH

// register indices on the internal register port
`define OFS_FLAGS_ZERO     4'h0
`define OFS_FLAGS_ONE      4'h1
`define OFS_ENABLE_ZERO    4'h2
`define OFS_ENABLE_ONE     4'h3
`define OFS_PHASE_STATE    4'h4
`define OFS_ACTIVE_THR     4'h5
`define OFS_REACTIVE_THR   4'h6
`define OFS_APPARENT_THR   4'h7

// bit positions in the second flag group
`define BIT_TOTAL_IDLE     0
`define BIT_FUND_IDLE      1
`define BIT_APPARENT_IDLE  2
`define BIT_RESET_DONE     15

// phase field positions in the phase state register
`define POS_TOTAL_PHASE    0
`define POS_FUND_PHASE     3
`define POS_APPARENT_PHASE 6

// reset values
`define RST_ENABLE         32'h0000_0000
`define RST_FLAGS          32'h0000_0000
`define RST_THRESHOLD      24'h00_0000

`endif

// ### hdl/noload_pkg.sv
/*
 Types for the no-load detector: per-phase power sample and register
 port request and answer.
 Assumes a 28-bit signed power datapath.
*/
package noload_pkg;

   typedef struct packed {
      logic signed [27:0] total_active;
      logic signed [27:0] total_reactive;
      logic signed [27:0] fund_active;
      logic signed [27:0] fund_reactive;
      logic signed [27:0] apparent;
   } phase_power_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } reg_rsp_t;

endpackage

// ### hdl/noload_detect_irq_status.sv
/*
 No-load detection for total, fundamental and apparent power on three
 phases, with the two event flag groups, enable registers and the two
 active-low interrupt lines.
 Assumes power samples and register requests come from logic on sys_clk.
*/
// ==========================================
`timescale 1ns/10ps
`include "noload_consts.svh"
`default_nettype none

module noload_detect_irq_status (
   input  wire logic                           sys_clk,
   input  wire logic                           srst,
   input  wire noload_pkg::phase_power_t [2:0] power_in,
   input  wire logic                           power_valid,
   input  wire logic [31:0]                    events_zero,
   input  wire logic [31:0]                    events_one,
   input  wire noload_pkg::reg_req_t           reg_req,
   output var  noload_pkg::reg_rsp_t           reg_rsp,
   output var  logic [8:0]                     energy_hold,
   output var  logic                           interrupt_line_zero_n,
   output var  logic                           interrupt_line_one_n
);
   import noload_pkg::*;

   // ==========================================
   // declarations
   logic [31:0] flags_zero_reg;
   logic [31:0] flags_one_reg;
   logic [31:0] enable_zero_reg;
   logic [31:0] enable_one_reg;
   logic [23:0] active_thr_reg;
   logic [23:0] reactive_thr_reg;
   logic [23:0] apparent_thr_reg;
   logic [2:0]  total_state_reg;
   logic [2:0]  fund_state_reg;
   logic [2:0]  app_state_reg;
   logic        reset_done_pend_reg;
   logic [2:0]  total_next;
   logic [2:0]  fund_next;
   logic [2:0]  app_next;
   logic        pq_enabled;
   logic        app_enabled;
   logic [31:0] own_events;
   logic [31:0] clear_zero;
   logic [31:0] clear_one;
   logic [31:0] flags_zero_next;
   logic [31:0] flags_one_next;
   logic [31:0] enable_one_eff;
   logic [15:0] phase_state;

   // magnitude at or below a 24-bit threshold sign-extended to 29 bits
   function automatic logic under_threshold(input logic signed [27:0] p,
                                            input logic [23:0] thr);
      logic signed [28:0] wide;
      logic        [28:0] mag;
      logic        [28:0] lim;
      wide = {p[27], p};
      mag  = wide[28] ? 29'(-wide) : 29'(wide);
      lim  = {{5{thr[23]}}, thr};
      return mag <= lim;
   endfunction

   // ==========================================
   // per-phase detection
   assign pq_enabled  = !(active_thr_reg[23] && reactive_thr_reg[23]);
   assign app_enabled = !apparent_thr_reg[23];

   for (genvar ph = 0; ph < 3; ph++) begin : g_phase
      assign total_next[ph] = pq_enabled
         && under_threshold(power_in[ph].total_active, active_thr_reg)
         && under_threshold(power_in[ph].total_reactive, reactive_thr_reg);
      assign fund_next[ph] = pq_enabled
         && under_threshold(power_in[ph].fund_active, active_thr_reg)
         && under_threshold(power_in[ph].fund_reactive, reactive_thr_reg);
      assign app_next[ph] = app_enabled
         && under_threshold(power_in[ph].apparent, apparent_thr_reg);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         total_state_reg <= 3'h0;
         fund_state_reg  <= 3'h0;
         app_state_reg   <= 3'h0;
      end else if (power_valid) begin
         total_state_reg <= total_next;
         fund_state_reg  <= fund_next;
         app_state_reg   <= app_next;
      end
   end

   // ==========================================
   // event flags
   always_comb begin
      own_events = 32'h0000_0000;
      own_events[`BIT_TOTAL_IDLE]    = power_valid && (total_next != total_state_reg);
      own_events[`BIT_FUND_IDLE]     = power_valid && (fund_next != fund_state_reg);
      own_events[`BIT_APPARENT_IDLE] = power_valid && (app_next != app_state_reg);
      own_events[`BIT_RESET_DONE]    = reset_done_pend_reg;
   end

   assign clear_zero = (reg_req.wr && reg_req.addr == `OFS_FLAGS_ZERO) ? reg_req.wdata
                                                                        : 32'h0000_0000;
   assign clear_one  = (reg_req.wr && reg_req.addr == `OFS_FLAGS_ONE) ? reg_req.wdata
                                                                       : 32'h0000_0000;
   // set wins over a clear in the same cycle
   assign flags_zero_next = (flags_zero_reg & ~clear_zero) | events_zero;
   assign flags_one_next  = (flags_one_reg & ~clear_one) | events_one | own_events;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flags_zero_reg      <= `RST_FLAGS;
         flags_one_reg       <= `RST_FLAGS;
         reset_done_pend_reg <= 1'b1;
      end else begin
         flags_zero_reg      <= flags_zero_next;
         flags_one_reg       <= flags_one_next;
         reset_done_pend_reg <= 1'b0;
      end
   end

   // ==========================================
   // enables and thresholds
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         enable_zero_reg  <= `RST_ENABLE;
         enable_one_reg   <= `RST_ENABLE;
         active_thr_reg   <= `RST_THRESHOLD;
         reactive_thr_reg <= `RST_THRESHOLD;
         apparent_thr_reg <= `RST_THRESHOLD;
      end else if (reg_req.wr) begin
         unique case (reg_req.addr)
            `OFS_ENABLE_ZERO:  enable_zero_reg  <= reg_req.wdata;
            `OFS_ENABLE_ONE:   enable_one_reg   <= reg_req.wdata;
            `OFS_ACTIVE_THR:   active_thr_reg   <= reg_req.wdata[23:0];
            `OFS_REACTIVE_THR: reactive_thr_reg <= reg_req.wdata[23:0];
            `OFS_APPARENT_THR: apparent_thr_reg <= reg_req.wdata[23:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // interrupt lines
   always_comb begin
      enable_one_eff = enable_one_reg;
      enable_one_eff[`BIT_RESET_DONE] = 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         interrupt_line_zero_n <= 1'b1;
         interrupt_line_one_n  <= 1'b1;
      end else begin
         interrupt_line_zero_n <= ~|(flags_zero_reg & enable_zero_reg);
         interrupt_line_one_n  <= ~|(flags_one_reg & enable_one_eff);
      end
   end

   // ==========================================
   // register reads and hold outputs
   assign phase_state = {7'h00, app_state_reg, fund_state_reg, total_state_reg};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rsp <= '0;
      end else begin
         reg_rsp.valid <= reg_req.rd;
         if (!reg_req.rd) begin
            reg_rsp.data <= 32'h0000_0000;
         end else begin
            unique case (reg_req.addr)
               `OFS_FLAGS_ZERO:   reg_rsp.data <= flags_zero_reg;
               `OFS_FLAGS_ONE:    reg_rsp.data <= flags_one_reg;
               `OFS_ENABLE_ZERO:  reg_rsp.data <= enable_zero_reg;
               `OFS_ENABLE_ONE:   reg_rsp.data <= enable_one_reg;
               `OFS_PHASE_STATE:  reg_rsp.data <= {16'h0000, phase_state};
               `OFS_ACTIVE_THR:   reg_rsp.data <= {4'h0, {4{active_thr_reg[23]}},
                                                   active_thr_reg};
               `OFS_REACTIVE_THR: reg_rsp.data <= {4'h0, {4{reactive_thr_reg[23]}},
                                                   reactive_thr_reg};
               `OFS_APPARENT_THR: reg_rsp.data <= {4'h0, {4{apparent_thr_reg[23]}},
                                                   apparent_thr_reg};
               default:           reg_rsp.data <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         energy_hold <= 9'h000;
      end else begin
         energy_hold <= phase_state[8:0];
      end
   end

   // ==========================================
   // assertions
   irq_one_low_a: assert property (@(posedge sys_clk) disable iff (srst)
      |(flags_one_reg & enable_one_eff) |=> !interrupt_line_one_n)
      else $error("line one not low with enabled flag");

   irq_zero_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      !(|(flags_zero_reg & enable_zero_reg)) |=> interrupt_line_zero_n)
      else $error("line zero low without enabled flag");

   reset_done_a: assert property (@(posedge sys_clk)
      $fell(srst) |=> flags_one_reg[`BIT_RESET_DONE] ##1 !interrupt_line_one_n)
      else $error("reset done flag or line missing");

   enable_reset_a: assert property (@(posedge sys_clk)
      srst |=> (enable_zero_reg == 32'h0000_0000) && (enable_one_reg == 32'h0000_0000))
      else $error("enables not zero after reset");

   fund_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && (fund_next != fund_state_reg) |=> flags_one_reg[`BIT_FUND_IDLE]
      && (fund_state_reg == $past(fund_next)))
      else $error("fundamental flag or phase bits wrong");

   fund_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && active_thr_reg[23] && reactive_thr_reg[23] |=> fund_state_reg == 3'h0)
      else $error("fundamental test not disabled");

   app_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && apparent_thr_reg[23] |=> app_state_reg == 3'h0 ##1 energy_hold[8:6] == 3'h0)
      else $error("apparent test not disabled");

   flag_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
      reg_req.wr && reg_req.addr == `OFS_FLAGS_ONE && reg_req.wdata[`BIT_APPARENT_IDLE]
      && !own_events[`BIT_APPARENT_IDLE] && !events_one[`BIT_APPARENT_IDLE]
      |=> !flags_one_reg[`BIT_APPARENT_IDLE])
      else $error("write one did not clear flag");

   set_wins_a: assert property (@(posedge sys_clk) disable iff (srst)
      own_events[`BIT_TOTAL_IDLE] |=> flags_one_reg[`BIT_TOTAL_IDLE])
      else $error("total flag lost");

   thr_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      reg_req.rd && reg_req.addr == `OFS_APPARENT_THR && !reg_req.wr
      |=> reg_rsp.valid && reg_rsp.data[31:28] == 4'h0
      && reg_rsp.data[27:24] == {4{reg_rsp.data[23]}})
      else $error("threshold read not sign extended");

   // limits for checking, thresholds taken as non-negative
   logic signed [27:0] act_lim;
   logic signed [27:0] react_lim;
   logic signed [27:0] app_lim;

   assign act_lim   = $signed({4'h0, active_thr_reg});
   assign react_lim = $signed({4'h0, reactive_thr_reg});
   assign app_lim   = $signed({4'h0, apparent_thr_reg});

   tot_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && (total_next != total_state_reg) |=> flags_one_reg[`BIT_TOTAL_IDLE]
      && (total_state_reg == $past(total_next)))
      else $error("total flag or phase bits wrong");

   app_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && (app_next != app_state_reg) |=> flags_one_reg[`BIT_APPARENT_IDLE]
      && (app_state_reg == $past(app_next)))
      else $error("apparent flag or phase bits wrong");

   phase_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      reg_req.rd && reg_req.addr == `OFS_PHASE_STATE |=> reg_rsp.data[31:9] == 23'h0
      && reg_rsp.data[8:6] == $past(app_state_reg)
      && reg_rsp.data[5:3] == $past(fund_state_reg)
      && reg_rsp.data[2:0] == $past(total_state_reg))
      else $error("phase state read wrong");

   hold_fund_a: assert property (@(posedge sys_clk) disable iff (srst)
      1'b1 |=> energy_hold[5:3] == $past(fund_state_reg))
      else $error("fundamental energy hold wrong");

   hold_app_a: assert property (@(posedge sys_clk) disable iff (srst)
      1'b1 |=> energy_hold[8:6] == $past(app_state_reg))
      else $error("apparent energy hold wrong");

   irq_zero_low_a: assert property (@(posedge sys_clk) disable iff (srst)
      |(flags_zero_reg & enable_zero_reg) |=> !interrupt_line_zero_n)
      else $error("line zero not low with enabled flag");

   irq_one_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      !(|(flags_one_reg & enable_one_eff)) |=> interrupt_line_one_n)
      else $error("line one low without enabled flag");

   done_unmask_a: assert property (@(posedge sys_clk) disable iff (srst)
      flags_one_reg[`BIT_RESET_DONE] |=> !interrupt_line_one_n)
      else $error("reset done flag masked");

   sticky_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
      !(reg_req.wr && reg_req.addr == `OFS_FLAGS_ZERO)
      |=> (flags_zero_reg & $past(flags_zero_reg)) == $past(flags_zero_reg))
      else $error("group zero flag dropped without clear");

   event_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
      |events_zero |=> (flags_zero_reg & $past(events_zero)) == $past(events_zero))
      else $error("group zero event not flagged");

   event_one_a: assert property (@(posedge sys_clk) disable iff (srst)
      |events_one |=> (flags_one_reg & $past(events_one)) == $past(events_one))
      else $error("group one event not flagged");

   fund_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && !active_thr_reg[23] && !reactive_thr_reg[23]
      && $signed(power_in[0].fund_active) <= act_lim
      && $signed(power_in[0].fund_active) >= -act_lim
      && $signed(power_in[0].fund_reactive) <= react_lim
      && $signed(power_in[0].fund_reactive) >= -react_lim |=> fund_state_reg[0])
      else $error("fundamental idle not detected");

   total_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && !active_thr_reg[23] && !reactive_thr_reg[23]
      && $signed(power_in[1].total_active) <= act_lim
      && $signed(power_in[1].total_active) >= -act_lim
      && $signed(power_in[1].total_reactive) <= react_lim
      && $signed(power_in[1].total_reactive) >= -react_lim |=> total_state_reg[1])
      else $error("total idle not detected");

   app_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && !apparent_thr_reg[23]
      && $signed(power_in[1].apparent) <= app_lim
      && $signed(power_in[1].apparent) >= -app_lim |=> app_state_reg[1])
      else $error("apparent idle not detected");

   fund_busy_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && !active_thr_reg[23] && $signed(power_in[2].fund_active) > act_lim
      |=> !fund_state_reg[2])
      else $error("fundamental idle with power above threshold");

   shared_thr_a: assert property (@(posedge sys_clk) disable iff (srst)
      power_valid && power_in[2].fund_active == power_in[2].total_active
      && power_in[2].fund_reactive == power_in[2].total_reactive
      |=> fund_state_reg[2] == total_state_reg[2])
      else $error("fundamental and total thresholds differ");

endmodule

`default_nettype wire

// ### tb/noload_host_model.sv
/*
 Host model: register reads and writes, and the flag service sequence.
 Assumes the register port of noload_detect_irq_status on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// host register access
module noload_host_model (
   input  wire logic                 sys_clk,
   output var  noload_pkg::reg_req_t reg_req,
   input  wire noload_pkg::reg_rsp_t reg_rsp
);
   import noload_pkg::*;
`include "noload_consts.svh"
   initial reg_req = '0;
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(posedge sys_clk);
      reg_req <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
      @(posedge sys_clk);
      @(posedge sys_clk);
      d = (reg_rsp.valid === 1'h1) ? reg_rsp.data : 'x;
      reg_req <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: 32'hFFFF_FFFF};
   endtask
   // flags, then phase detail, then same value back
   task automatic service(input logic [3:0] fo, output logic [31:0] f, output logic [31:0] p);
      rd(fo, f);
      rd(`OFS_PHASE_STATE, p);
      wr(fo, f);
   endtask
endmodule
`default_nettype wire

// ### tb/tb_noload_detect_irq_status.sv
/*
 Testbench for noload_detect_irq_status: thresholds, idle detection,
 flags, enables and both interrupt lines.
 Assumes noload_host_model drives the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_noload_detect_irq_status;
   import noload_pkg::*;
`include "noload_consts.svh"
   logic                   sys_clk = 1'h0;
   logic                   srst = 1'h1;
   phase_power_t [2:0]     power_in = '0;
   logic                   power_valid = 1'h0;
   logic [31:0]            events_zero = 32'h0;
   logic [31:0]            events_one = 32'h0;
   reg_req_t               reg_req;
   reg_rsp_t               reg_rsp;
   logic [8:0]             energy_hold;
   logic                   line_zero_n;
   logic                   line_one_n;
   int                     err_total = 0;
   int                     checked = 0;
   phase_power_t           pa, pb, pc;
   logic [31:0]            f, p;
   always #20 sys_clk = ~sys_clk;
   noload_detect_irq_status dut (.sys_clk(sys_clk), .srst(srst), .power_in(power_in),
      .power_valid(power_valid), .events_zero(events_zero), .events_one(events_one),
      .reg_req(reg_req), .reg_rsp(reg_rsp), .energy_hold(energy_hold),
      .interrupt_line_zero_n(line_zero_n), .interrupt_line_one_n(line_one_n));
   noload_host_model host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
   // ==========================================
   // tasks
   task automatic test_done;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: line %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      host.rd(a, d);
      chk32(d, exp);
   endtask
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic sample;
      @(posedge sys_clk);
      power_in <= {pc, pb, pa};
      power_valid <= 1'h1;
      @(posedge sys_clk);
      power_valid <= 1'h0;
      settle();
   endtask
   task automatic ev(input logic [31:0] z, input logic [31:0] o);
      @(posedge sys_clk);
      events_zero <= z;
      events_one <= o;
      @(posedge sys_clk);
      events_zero <= 32'h0;
      events_one <= 32'h0;
      settle();
   endtask
   function automatic phase_power_t pw(input int ta, tr, fa, fr, ap);
      pw = '{total_active: 28'(ta), total_reactive: 28'(tr), fund_active: 28'(fa),
             fund_reactive: 28'(fr), apparent: 28'(ap)};
   endfunction
   // ==========================================
   // tests
   initial begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'h0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk1(line_one_n, 1'h0);
      chk1(line_zero_n, 1'h1);
      rd_chk(`OFS_ENABLE_ZERO, 32'h0);
      rd_chk(`OFS_ENABLE_ONE, 32'h0);
      rd_chk(`OFS_FLAGS_ONE, 32'h0000_8000);
      host.wr(`OFS_FLAGS_ONE, 32'h0000_8000);
      settle();
      chk1(line_one_n, 1'h1);
      host.wr(`OFS_ACTIVE_THR, 32'h64);
      host.wr(`OFS_REACTIVE_THR, 32'h64);
      host.wr(`OFS_APPARENT_THR, 32'h0080_0000);
      rd_chk(`OFS_APPARENT_THR, 32'h0F80_0000);
      host.wr(`OFS_APPARENT_THR, 32'hC8);
      pa = pw(500, 0, -100, 50, 300);
      pb = pw(0, 0, 101, 0, -200);
      pc = pw(1000, 1000, 1000, 1000, 1000);
      sample();
      chk1(line_one_n, 1'h1);
      chk32({23'h0, energy_hold}, 32'h8A);
      rd_chk(`OFS_PHASE_STATE, 32'h8A);
      rd_chk(`OFS_FLAGS_ONE, 32'h7);
      host.wr(`OFS_ENABLE_ONE, 32'h2);
      settle();
      chk1(line_one_n, 1'h0);
      host.service(`OFS_FLAGS_ONE, f, p);
      chk32(p, 32'h8A);
      settle();
      chk1(line_one_n, 1'h1);
      host.wr(`OFS_ENABLE_ONE, 32'h4);
      host.wr(`OFS_ACTIVE_THR, 32'hFF_FFFF);
      host.wr(`OFS_REACTIVE_THR, 32'hFF_FFFF);
      sample();
      chk1(line_one_n, 1'h1);
      rd_chk(`OFS_PHASE_STATE, 32'h80);
      host.wr(`OFS_APPARENT_THR, 32'hFF_FFFF);
      sample();
      chk1(line_one_n, 1'h0);
      rd_chk(`OFS_PHASE_STATE, 32'h0);
      rd_chk(`OFS_FLAGS_ONE, 32'h7);
      host.wr(`OFS_FLAGS_ONE, 32'h7);
      ev(32'h0, 32'h0000_8000);
      chk1(line_one_n, 1'h0);
      host.wr(`OFS_FLAGS_ONE, 32'h0000_8000);
      host.wr(`OFS_ENABLE_ZERO, 32'h200);
      ev(32'h600, 32'h0);
      chk1(line_zero_n, 1'h0);
      rd_chk(`OFS_FLAGS_ZERO, 32'h600);
      host.wr(`OFS_FLAGS_ZERO, 32'h200);
      settle();
      chk1(line_zero_n, 1'h1);
      chk1(line_one_n, 1'h1);
      rd_chk(`OFS_FLAGS_ZERO, 32'h400);
      host.wr(`OFS_PHASE_STATE, 32'h1FF);
      rd_chk(`OFS_PHASE_STATE, 32'h0);
      rd_chk(4'h8, 32'h0);
      test_done();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      test_done();
   end
endmodule
`default_nettype wire
